// *** rtl/serial_channel_pkg.sv ***
/*
  package for the serial channel: register map, field positions, reset
  values and coding enumerations. assumes a 32-bit axi4-lite register bus.
*/
package serial_channel_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SPECIAL = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_REG7 = 8'h1c;
  localparam logic [7:0] ADDR_EXT_RB = 8'h38;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h3c;
  localparam logic [7:0] ADDR_MODE_RB = 8'h24;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int XF_READ_EN = 6;
  localparam int XF_TX_LEVEL = 5;
  localparam int XF_RX_LEVEL = 3;
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_EMPTY = 2;
  localparam int EC_EXT_ACCESS = 0;
  localparam logic [7:0] XF_RESET = 8'h20;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] EC_RESET = 8'h00;
  localparam logic [3:0] TX_DEPTH = 4'h4;
  localparam logic [3:0] RX_DEPTH = 4'h8;
  localparam logic [3:0] RX_HALF = 4'h4;
  localparam logic [4:0] DIV_NRZI = 5'h1f;
  localparam logic [4:0] DIV_BIPH = 5'h0f;
  localparam logic [4:0] CNT_NOM_CENTRE = 5'h0f;
  localparam logic [4:0] WIN_LO = 5'h0c;
  localparam logic [4:0] WIN_HI = 5'h13;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CODE_NRZ = 2'b00,
    CODE_NRZI = 2'b01,
    CODE_MARK = 2'b10,
    CODE_SPACE = 2'b11
  } coding_t;

  typedef enum logic [1:0] {
    LB_NORMAL = 2'b00,
    LB_ECHO = 2'b01,
    LB_LOCAL = 2'b10
  } loop_t;
endpackage : serial_channel_pkg

// *** rtl/byte_fifo_mem.sv ***
/*
  small byte memory used by the channel fifos; registered read data.
  assumes one write and one read port on aclk.
*/
`timescale 1ns/100ps
module byte_fifo_mem #(
  parameter int AW = 3
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : byte_fifo_mem

// *** rtl/serial_channel.sv ***
/*
  one serial channel: clock recovery loop, line coding, echo and loopback,
  4-byte transmit and 8-byte receive fifos, extended feature register.
  assumes an axi4-lite master, pins already resolved to plain signals.
*/
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module serial_channel
  import serial_channel_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_clock_input_pin,
  input wire logic baud_clock,
  input wire logic serial_in_pin,
  input wire logic rx_special_in,
  output logic serial_out_pin,
  output logic clock_io_pin_o,
  output logic clock_io_pin_oe,
  output logic tx_request,
  output logic rx_request,
  output logic tx_empty_irq,
  output logic rx_avail_irq,
  output logic special_irq
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  always_ff @(posedge aclk) begin
    meta_q <= {rx_special_in, serial_in_pin, baud_clock, shared_clock_input_pin};
    sync_q <= meta_q;
  end
  wire pin_clk_s = sync_q[0];
  wire brg_s = sync_q[1];
  wire rxd_s = sync_q[2];
  wire spec_s = sync_q[3];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] xf_q;
  logic [7:0] sync_char_q;
  logic [7:0] ext_ctrl_q;
  logic [7:0] mode_q;
  // mode: [1:0] coding, [3:2] loop, [4] loop src baud, [5] clock pin out,
  // [6] tx request en, [7] rx request en
  wire coding_t coding = coding_t'(mode_q[1:0]);
  wire loop_t loop_mode = loop_t'(mode_q[3:2]);
  wire src_baud = mode_q[4];
  wire clk_out_en = mode_q[5];
  wire txreq_en = mode_q[6];
  wire rxreq_en = mode_q[7];

  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_lane0 = wstrb_q[0];
  wire wr_data = do_write && awaddr_q == ADDR_DATA && wr_lane0;
  wire wr_mode = do_write && awaddr_q == ADDR_MODE && wr_lane0;
  wire wr_reg7 = do_write && awaddr_q == ADDR_REG7 && wr_lane0;
  wire wr_ectl = do_write && awaddr_q == ADDR_EXT_CTRL && wr_lane0;
  wire wr_known = awaddr_q == ADDR_DATA || awaddr_q == ADDR_MODE || awaddr_q == ADDR_REG7 ||
                  awaddr_q == ADDR_EXT_CTRL;
  wire wr_xf = wr_reg7 && ext_ctrl_q[EC_EXT_ACCESS];
  wire wr_sync = wr_reg7 && !ext_ctrl_q[EC_EXT_ACCESS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      // readies kept in flops, low from take until the response is gone
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xf_q <= XF_RESET;
      sync_char_q <= SYNC_RESET;
      ext_ctrl_q <= EC_RESET;
      mode_q <= MODE_RESET;
    end else begin
      if (wr_xf) begin
        xf_q <= wdata_q[7:0];
      end
      if (wr_sync) begin
        sync_char_q <= wdata_q[7:0];
      end
      if (wr_ectl) begin
        ext_ctrl_q <= wdata_q[7:0];
      end
      if (wr_mode) begin
        mode_q <= wdata_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  // always active, flushed by reset
  logic [1:0] tx_wp_q;
  logic [1:0] tx_rp_q;
  logic [2:0] tx_cnt_q;
  logic [7:0] tx_head;
  logic [7:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic bit_tick;
  logic mid_tick;
  wire tx_full = tx_cnt_q == 3'(TX_DEPTH);
  wire tx_push = wr_data && !tx_full;
  wire tx_load = bit_tick && tx_bits_q == 4'h0 && tx_cnt_q != 3'h0;
  wire tx_pop = tx_load;
  wire tx_top_empty = !tx_full;
  byte_fifo_mem #(.AW(2)) u_tx_mem (
    .aclk(aclk),
    .we(tx_push),
    .waddr(tx_wp_q),
    .wdata(wdata_q[7:0]),
    .raddr(tx_rp_q),
    .rdata(tx_head)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wp_q <= 2'h0;
      tx_rp_q <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else begin
      tx_wp_q <= tx_wp_q + 2'(tx_push);
      tx_rp_q <= tx_rp_q + 2'(tx_pop);
      tx_cnt_q <= tx_cnt_q + 3'(tx_push) - 3'(tx_pop);
    end
  end

  // ----------------------------------------------------------------
  // clock recovery loop
  // ----------------------------------------------------------------
  // source select
  wire src_lvl = src_baud ? brg_s : pin_clk_s;
  logic txd_q;
  logic src_prev_q;
  logic rxd_prev_q;
  logic [4:0] cnt_q;
  logic [4:0] adj_q;
  logic out_clk_q;
  wire src_tick = src_lvl && !src_prev_q;
  wire biphase = coding == CODE_MARK || coding == CODE_SPACE;
  // in local loopback, internal transmit data feeds the receiver
  wire line_in = loop_mode == LB_LOCAL ? txd_q : rxd_s;
  wire rx_edge = line_in != rxd_prev_q;
  wire [4:0] div_top = biphase ? DIV_BIPH : DIV_NRZI;
  wire in_win = cnt_q >= WIN_LO && cnt_q <= WIN_HI;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 1'b0;
      rxd_prev_q <= 1'b1;
      cnt_q <= 5'h00;
      adj_q <= 5'h00;
      out_clk_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
      rxd_prev_q <= line_in;
      if (src_tick) begin
        if (!biphase && cnt_q == DIV_NRZI) begin
          cnt_q <= adj_q;
          adj_q <= 5'h00;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
        if ((cnt_q & div_top) == div_top) begin
          out_clk_q <= ~out_clk_q;
        end
      end
      if (rx_edge && !biphase && src_tick) begin
        adj_q <= cnt_q > CNT_NOM_CENTRE ? 5'h01 : 5'h1f;
      end
      if (rx_edge && biphase && in_win) begin
        cnt_q <= 5'h10;
      end
    end
  end
  assign bit_tick = src_tick && ((cnt_q & div_top) == div_top);
  assign mid_tick = src_tick && ((cnt_q & div_top) == (div_top >> 1));

  // ----------------------------------------------------------------
  // transmitter and line coding
  // ----------------------------------------------------------------
  wire cur_bit = tx_shift_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift_q <= 8'hff;
      tx_bits_q <= 4'h0;
      txd_q <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_shift_q <= tx_head;
        tx_bits_q <= 4'h8;
      end else if (bit_tick && tx_bits_q != 4'h0) begin
        tx_shift_q <= {1'b1, tx_shift_q[7:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
      end
      if (bit_tick) begin
        case (coding)
          CODE_NRZ: txd_q <= cur_bit;
          CODE_NRZI: txd_q <= cur_bit ? txd_q : ~txd_q;
          default: txd_q <= ~txd_q;
        endcase
      end else if (mid_tick) begin
        // mark mid for one, space mid for zero
        if ((coding == CODE_MARK && cur_bit) || (coding == CODE_SPACE && !cur_bit)) begin
          txd_q <= ~txd_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver and receive fifo
  // ----------------------------------------------------------------
  logic [7:0] rx_shift_q;
  logic [3:0] rx_bits_q;
  logic [2:0] rx_wp_q;
  logic [2:0] rx_rp_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_special_q;
  logic [7:0] rx_head;
  logic prev_bit_q;
  // biphase receiver samples on mid_tick: level is the bit inverted; nrz and nrzi sample on bit_tick
  wire samp = biphase ? mid_tick : bit_tick;
  wire rx_bit = coding == CODE_NRZI ? (line_in == prev_bit_q) : (biphase ? ~line_in : line_in);
  wire rx_done = samp && rx_bits_q == 4'h7;
  wire rx_push = rx_done && rx_cnt_q != RX_DEPTH;
  wire rd_data = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_DATA;
  wire rx_pop = rd_data && rx_cnt_q != 4'h0;
  byte_fifo_mem #(.AW(3)) u_rx_mem (
    .aclk(aclk),
    .we(rx_push),
    .waddr(rx_wp_q),
    .wdata({rx_bit, rx_shift_q[7:1]}),
    .raddr(rx_rp_q),
    .rdata(rx_head)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift_q <= 8'h00;
      rx_bits_q <= 4'h0;
      rx_wp_q <= 3'h0;
      rx_rp_q <= 3'h0;
      rx_cnt_q <= 4'h0;
      rx_special_q <= 8'h00;
      prev_bit_q <= 1'b1;
    end else begin
      if (samp) begin
        rx_shift_q <= {rx_bit, rx_shift_q[7:1]};
        rx_bits_q <= rx_done ? 4'h0 : rx_bits_q + 4'h1;
        prev_bit_q <= line_in;
      end
      rx_wp_q <= rx_wp_q + 3'(rx_push);
      rx_rp_q <= rx_rp_q + 3'(rx_pop);
      rx_cnt_q <= rx_cnt_q + 4'(rx_push) - 4'(rx_pop);
      if (rx_push) begin
        rx_special_q[rx_wp_q] <= spec_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // requests and level flags
  // ----------------------------------------------------------------
  // special byte within top four
  logic spec_top4;
  always_comb begin
    spec_top4 = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (4'(i) < rx_cnt_q && rx_special_q[3'(rx_rp_q + 3'(i))]) begin
        spec_top4 = 1'b1;
      end
    end
  end
  wire echo_mode = loop_mode == LB_ECHO;
  // level one: tx only when fifo empty, rx from half full
  wire tx_irq_d = xf_q[XF_TX_LEVEL] ? tx_cnt_q == 3'h0 : tx_top_empty;
  wire rx_irq_d = xf_q[XF_RX_LEVEL] ? rx_cnt_q >= RX_HALF : rx_cnt_q != 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_request <= 1'b0;
      rx_request <= 1'b0;
      tx_empty_irq <= 1'b0;
      rx_avail_irq <= 1'b0;
      special_irq <= 1'b0;
      serial_out_pin <= 1'b1;
      clock_io_pin_o <= 1'b0;
      clock_io_pin_oe <= 1'b0;
    end else begin
      tx_request <= txreq_en && tx_irq_d && !wr_data && !tx_push;
      // drop for one cycle after each read of the data register
      rx_request <= rxreq_en && rx_cnt_q != 4'h0 && !rx_pop && !rd_data;
      tx_empty_irq <= tx_irq_d;
      rx_avail_irq <= rx_irq_d;
      special_irq <= spec_top4;
      serial_out_pin <= (echo_mode || loop_mode == LB_LOCAL) ? rxd_s : txd_q;
      clock_io_pin_o <= out_clk_q;
      clock_io_pin_oe <= clk_out_en;
    end
  end

  // ----------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------
  // readback gated by read enable
  wire xrd = xf_q[XF_READ_EN];
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_DATA: rd_byte = rx_head;
      ADDR_STATUS: rd_byte = {5'h00, tx_top_empty, 1'b0, rx_cnt_q != 4'h0};
      ADDR_SPECIAL: rd_byte = {7'h00, rx_cnt_q != 4'h0 && rx_special_q[rx_rp_q]};
      ADDR_EXT_RB: rd_byte = xrd ? xf_q : 8'h00;
      ADDR_MODE_RB: rd_byte = xrd ? mode_q : 8'h00;
      ADDR_EXT_CTRL: rd_byte = ext_ctrl_q;
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rd_byte};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : serial_channel

// *** bench/serial_channel_properties.sv ***
/*
  concurrent checks on the serial channel ports.
  assumes it is bound to every serial_channel instance.
*/
`timescale 1ns/100ps
module serial_channel_checker
  import serial_channel_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_out_pin,
  input wire logic clock_io_pin_oe,
  input wire logic tx_request,
  input wire logic tx_empty_irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("bad write response code");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // ------------------------------------------------------------
  // state after reset
  // ------------------------------------------------------------
  chk_reset_idle: assert property ($rose(aresetn) |-> serial_out_pin && !clock_io_pin_oe && !tx_request)
    else $error("line not idle after reset");
  chk_empty_irq: assert property ($rose(aresetn) |-> ##[1:2] tx_empty_irq)
    else $error("empty fifo not flagged after reset");
endmodule : serial_channel_checker

bind serial_channel serial_channel_checker chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_out_pin(serial_out_pin),
  .clock_io_pin_oe(clock_io_pin_oe), .tx_request(tx_request), .tx_empty_irq(tx_empty_irq)
);

// *** bench/line_partner.sv ***
/*
  serial line partner: source clocks and line data.
  assumes the bench steps run, bit_in and flag_in after aclk edges.
*/
`timescale 1ns/100ps
module line_partner (
  input wire logic aclk,
  input wire logic run,
  input wire logic bit_in,
  input wire logic flag_in,
  output logic src_clk,
  output logic baud_clk,
  output logic line_out,
  output logic special
);
  logic [2:0] div_q;
  always @(posedge aclk) begin
    div_q <= run ? div_q + 3'h1 : 3'h0;
    src_clk <= run & div_q[0];
    baud_clk <= run & div_q[2];
    // marking line idles high outside frames
    line_out <= run ? bit_in : 1'b1;
    special <= run & flag_in;
  end
endmodule : line_partner

// *** bench/tb_top.sv ***
/*
  self-checking bench for the serial channel.
  assumes the checker is bound and the line partner drives the pins.
*/
`timescale 1ns/100ps
module tb_top
  import serial_channel_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic run, bit_in, flag_in, src_clk, baud_clk, line_in, special, ser_out, clk_o, clk_oe;
  logic tx_req, rx_req, tx_irq, rx_irq, sp_irq, b;
  logic [7:0] v;
  int err_count, check_count;

  serial_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shared_clock_input_pin(src_clk),
    .baud_clock(baud_clk), .serial_in_pin(line_in), .rx_special_in(special), .serial_out_pin(ser_out),
    .clock_io_pin_o(clk_o), .clock_io_pin_oe(clk_oe), .tx_request(tx_req), .rx_request(rx_req),
    .tx_empty_irq(tx_irq), .rx_avail_irq(rx_irq), .special_irq(sp_irq));
  line_partner line_i (.aclk(aclk), .run(run), .bit_in(bit_in), .flag_in(flag_in), .src_clk(src_clk),
    .baud_clk(baud_clk), .line_out(line_in), .special(special));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // readback shows the extension only with its read enable set
  function automatic logic [31:0] xf_expect(input logic [7:0] x);
    return x[XF_READ_EN] ? {24'h0, x} : 32'h0;
  endfunction : xf_expect

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      err_count++;
      close_out();
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      err_count++;
      close_out();
    end
  endtask : axi_read

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask : settle

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run, bit_in, flag_in} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    err_count = 0;
    check_count = 0;
    void'($urandom(32'hfedafbee));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_STATUS, rd, rsp);
    check_word(rd & 32'h5, 32'h4);
    check_bit(ser_out, 1'b1);
    axi_write(ADDR_MODE, 32'hc0, rsp);
    settle(3);
    check_bit(tx_req, 1'b1);
    check_bit(rx_req, 1'b0);
    check_bit(rx_irq, 1'b0);
    check_bit(sp_irq, 1'b0);
    axi_write(ADDR_EXT_CTRL, 32'h01, rsp);
    axi_read(ADDR_EXT_CTRL, rd, rsp);
    check_bit(rd[EC_EXT_ACCESS], 1'b1);
    for (int i = 0; i < 6; i++) begin
      // host keeps the unused top bit clear
      v = (i == 0) ? 8'h40 : {2'b01, 6'($urandom)};
      axi_write(ADDR_REG7, {24'h0, v}, rsp);
      axi_read(ADDR_EXT_RB, rd, rsp);
      check_word(rd, xf_expect(v));
    end
    axi_write(ADDR_EXT_CTRL, 32'h00, rsp);
    axi_write(ADDR_REG7, 32'h5a, rsp);
    axi_read(ADDR_EXT_RB, rd, rsp);
    check_word(rd, xf_expect(v));
    axi_write(ADDR_EXT_CTRL, 32'h01, rsp);
    axi_write(ADDR_REG7, 32'h08, rsp);
    axi_read(ADDR_EXT_RB, rd, rsp);
    check_word(rd, xf_expect(8'h08));
    settle(3);
    check_bit(tx_req, 1'b1);
    axi_read(8'h80, rd, rsp);
    check_word({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    axi_write(8'h80, 32'h1, rsp);
    check_word({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_write(ADDR_MODE, 32'h20, rsp);
    settle(4);
    check_bit(clk_oe, 1'b1);
    // source clocks stopped: the fifo cannot drain, fifth byte is dropped
    axi_write(ADDR_MODE, 32'hc0, rsp);
    for (int i = 0; i < 5; i++) begin
      axi_write(ADDR_DATA, {24'h0, 8'($urandom)}, rsp);
    end
    axi_read(ADDR_STATUS, rd, rsp);
    check_word(rd & 32'h5, 32'h0);
    check_bit(tx_req, 1'b0);
    check_bit(tx_irq, 1'b0);
    axi_write(ADDR_REG7, 32'h20, rsp);
    axi_write(ADDR_MODE, 32'h80, rsp);
    b = 1'($urandom);
    bit_in <= b;
    flag_in <= b;
    run <= 1'b1;
    // one byte takes about 512 cycles, the second not before 1000
    settle(700);
    check_bit(rx_irq, 1'b1);
    check_bit(rx_req, 1'b1);
    check_bit(sp_irq, b);
    check_bit(tx_irq, 1'b0);
    axi_read(ADDR_SPECIAL, rd, rsp);
    check_word(rd, {31'h0, b});
    axi_read(ADDR_DATA, rd, rsp);
    check_word(rd, {24'h0, {8{b}}});
    settle(2);
    check_bit(rx_irq, 1'b0);
    b = clk_o;
    settle(64);
    check_bit(clk_o, ~b);
    run <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      axi_write(ADDR_MODE, (k % 2) ? 32'h08 : 32'h04, rsp);
      for (int j = 0; j < 5; j++) begin
        b = 1'($urandom);
        bit_in <= b;
        flag_in <= b;
        settle(8);
        check_bit(ser_out, b);
      end
    end
    run <= 1'b0;
    settle(4);
    close_out();
  end
endmodule : tb_top
